// *** core/cpt_path_seq.sv ***
// coordinated path sequencer with tangent follower and axi4-lite registers
`timescale 1ns/10ps
`include "cpt_consts.svh"
module cpt_path_seq
    import cpt_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [1:0] o_seq_run,
    output logic [31:0] o_vel,
    output logic [31:0] o_tan_target,
    output logic o_tan_en,
    output logic [11:0] o_plane_axes
);

function automatic logic [15:0] f_abs(input logic [15:0] v);
    return v[15] ? 16'(-v) : v;
endfunction : f_abs

// octagonal estimate of the vector length
function automatic logic [23:0] f_line_len(input logic [15:0] dx,
        input logic [15:0] dy);
    logic [15:0] ax;
    logic [15:0] ay;
    ax = f_abs(dx);
    ay = f_abs(dy);
    if (ax > ay)
        return 24'(ax) + 24'(ay >> 1);
    return 24'(ay) + 24'(ax >> 1);
endfunction : f_line_len

function automatic logic [23:0] f_arc_len(input logic [15:0] r,
        input logic [15:0] d);
    logic [47:0] p;
    p = 48'(r) * 48'(f_abs(d)) * 48'(`CPT_ARC_MUL);
    return p[39:16];
endfunction : f_arc_len

function automatic logic [31:0] f_tan(input logic [31:0] sc,
        input logic [31:0] ofs, input logic [15:0] ang);
    logic signed [47:0] p;
    p = 48'(signed'(sc)) * 48'(signed'(ang));
    return ofs + p[47:16];
endfunction : f_tan

////////////////////////////////////////////////////////////////////////////
// register bus
logic aw_got_q;
logic w_got_q;
logic [7:0] awaddr_q;
logic [31:0] wdata_q;
logic [3:0] wstrb_q;
logic wr_fire;
logic [31:0] rd_d;
logic rd_ok;
assign wr_fire = aw_got_q && w_got_q && !o_bvalid;

always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        awaddr_q <= 8'h00;
        wdata_q <= 32'h0000_0000;
        wstrb_q <= 4'h0;
        o_awready <= 1'b0;
        o_wready <= 1'b0;
        o_bvalid <= 1'b0;
        o_bresp <= `CPT_RESP_OK;
    end else begin
        o_awready <= !aw_got_q && !(i_awvalid && o_awready);
        o_wready <= !w_got_q && !(i_wvalid && o_wready);
        if (i_awvalid && o_awready) begin
            aw_got_q <= 1'b1;
            awaddr_q <= i_awaddr;
        end
        if (i_wvalid && o_wready) begin
            w_got_q <= 1'b1;
            wdata_q <= i_wdata;
            wstrb_q <= i_wstrb;
        end
        if (wr_fire) begin
            o_bvalid <= 1'b1;
            o_bresp <= (awaddr_q <= `CPT_A_PLANE && awaddr_q[1:0] == 2'h0)
                ? `CPT_RESP_OK : `CPT_RESP_ERR;
        end else if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
        end
    end
end

always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        o_arready <= 1'b0;
        o_rvalid <= 1'b0;
        o_rdata <= 32'h0000_0000;
        o_rresp <= `CPT_RESP_OK;
    end else begin
        o_arready <= !o_rvalid && !(i_arvalid && o_arready);
        if (i_arvalid && o_arready) begin
            o_rvalid <= 1'b1;
            o_rdata <= rd_d;
            o_rresp <= rd_ok ? `CPT_RESP_OK : `CPT_RESP_ERR;
        end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// settings
logic [31:0] arg_q [3];
logic [31:0] tscale_q;
logic [31:0] tofs_q;
logic [31:0] speed_q [2];
logic [31:0] accel_q [2];
logic [31:0] decel_q [2];
logic [31:0] ratio_q [2];
logic [4:0] smooth_q [2];
logic [11:0] plane_q;
logic csel_q;
logic blk_q;
logic [3:0] op;
logic cs;
logic go;
assign op = wdata_q[3:0];
assign cs = wdata_q[`CPT_CS_BIT];
assign go = wr_fire && awaddr_q == `CPT_A_CMD && !blk_q && wstrb_q[0];

always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        for (int i = 0; i < 3; i++)
            arg_q[i] <= 32'h0000_0000;
        for (int i = 0; i < 2; i++) begin
            speed_q[i] <= 32'h0000_0000;
            accel_q[i] <= 32'h0000_0000;
            decel_q[i] <= 32'h0000_0000;
            ratio_q[i] <= `CPT_RATIO_RST;
            smooth_q[i] <= 5'h00;
        end
        tscale_q <= 32'h0000_0000;
        tofs_q <= 32'h0000_0000;
        plane_q <= `CPT_PLANE_RST;
        csel_q <= 1'b0;
    end else begin
        if (wr_fire && wstrb_q == 4'hF) begin
            unique case (awaddr_q)
                `CPT_A_ARG0: arg_q[0] <= wdata_q;
                `CPT_A_ARG1: arg_q[1] <= wdata_q;
                `CPT_A_ARG2: arg_q[2] <= wdata_q;
                `CPT_A_TSCALE: tscale_q <= wdata_q;
                `CPT_A_TOFS: tofs_q <= wdata_q;
                `CPT_A_SPEED_S: speed_q[0] <= wdata_q;
                `CPT_A_SPEED_T: speed_q[1] <= wdata_q;
                `CPT_A_ACCEL_S: accel_q[0] <= wdata_q;
                `CPT_A_ACCEL_T: accel_q[1] <= wdata_q;
                `CPT_A_DECEL_S: decel_q[0] <= wdata_q;
                `CPT_A_DECEL_T: decel_q[1] <= wdata_q;
                `CPT_A_RATIO_S: ratio_q[0] <= wdata_q;
                `CPT_A_RATIO_T: ratio_q[1] <= wdata_q;
                `CPT_A_SMOOTH_S: smooth_q[0] <= wdata_q[4:0];
                `CPT_A_SMOOTH_T: smooth_q[1] <= wdata_q[4:0];
                default: ;
            endcase
        end
        if (go && op == `CPT_OP_PLANE)
            plane_q <= arg_q[0][11:0];
        if (go && op == `CPT_OP_CSEL)
            csel_q <= cs;
    end
end

////////////////////////////////////////////////////////////////////////////
// segment buffers, one ring per coordinate system
logic kind_m [2][512];
logic [23:0] len_m [2][512];
logic [15:0] dir_m [2][512];
logic [15:0] dx_m [2][512];
logic [15:0] dy_m [2][512];
cpt_ptr_t wr_q [2];
cpt_ptr_t rd_q [2];
cpt_ptr_t cnt_q [2];
cpt_run_e st_q [2];
logic end_q [2];
logic [31:0] seg_q [2];
logic [31:0] dist_q [2];
logic [31:0] plen_q [2];
logic [23:0] prog_q [2];
logic [31:0] vel_q [2];
logic signed [31:0] cx_q;
logic signed [31:0] cy_q;
logic push;
logic is_arc;
logic [15:0] arc_dir;
assign push = go && (op == `CPT_OP_LINE || op == `CPT_OP_ARC)
    && cnt_q[csel_q] != `CPT_CAP;
assign is_arc = op == `CPT_OP_ARC;
// heading at the arc start: start angle turned a quarter toward the sweep
assign arc_dir = arg_q[2][15] ? 16'(arg_q[1][15:0] - `CPT_QUARTER)
    : 16'(arg_q[1][15:0] + `CPT_QUARTER);

always_ff @(posedge i_ref_clk) begin
    if (push) begin
        kind_m[csel_q][wr_q[csel_q]] <= is_arc;
        len_m[csel_q][wr_q[csel_q]] <= is_arc
            ? f_arc_len(arg_q[0][15:0], arg_q[2][15:0])
            : f_line_len(arg_q[0][15:0], arg_q[1][15:0]);
        dir_m[csel_q][wr_q[csel_q]] <= is_arc ? arc_dir : arg_q[2][15:0];
        dx_m[csel_q][wr_q[csel_q]] <= is_arc ? 16'h0000 : arg_q[0][15:0];
        dy_m[csel_q][wr_q[csel_q]] <= is_arc ? 16'h0000 : arg_q[1][15:0];
    end
end

// speed target with ratio in 1/10000 steps
function automatic logic [31:0] f_tgt(input logic [31:0] sp,
        input logic [31:0] ra);
    logic [95:0] p;
    p = 96'(sp) * 96'(ra) * 96'(`CPT_RATIO_MUL);
    return p[`CPT_RATIO_SH+31:`CPT_RATIO_SH];
endfunction : f_tgt

// filtered step toward target, bounded by accel and decel
function automatic logic [31:0] f_step(input logic [31:0] v,
        input logic [31:0] t, input logic [31:0] a, input logic [31:0] d,
        input logic [4:0] sm);
    logic [31:0] e;
    e = (v < t) ? t - v : v - t;
    e = (e >> sm) | {31'h0, e != 32'h0};
    if (v < t)
        return v + ((e < a) ? e : a);
    return v - ((e < d) ? e : d);
endfunction : f_step

always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        for (int c = 0; c < 2; c++) begin
            wr_q[c] <= 9'h000;
            rd_q[c] <= 9'h000;
            cnt_q[c] <= 9'h000;
            st_q[c] <= CPT_IDLE;
            end_q[c] <= 1'b0;
            seg_q[c] <= 32'h0000_0000;
            dist_q[c] <= 32'h0000_0000;
            plen_q[c] <= 32'h0000_0000;
            prog_q[c] <= 24'h000000;
            vel_q[c] <= 32'h0000_0000;
        end
        cx_q <= 32'sh0000_0000;
        cy_q <= 32'sh0000_0000;
    end else begin
        for (int c = 0; c < 2; c++) begin
            logic [23:0] left;
            logic [31:0] tg;
            logic [31:0] nv;
            logic [24:0] np;
            logic last;
            logic [63:0] brake;
            left = len_m[c][rd_q[c]] - prog_q[c];
            last = end_q[c] && cnt_q[c] == 9'h001;
            brake = 64'(vel_q[c]) * 64'(vel_q[c]);
            tg = f_tgt(speed_q[c], ratio_q[c]);
            if (last && brake >= 64'(decel_q[c]) * 64'(left) * 64'h2)
                tg = 32'h0000_0000;
            nv = f_step(vel_q[c], tg, accel_q[c], decel_q[c], smooth_q[c]);
            if (nv == 32'h0000_0000)
                nv = 32'h0000_0001; // creep so the last segment finishes
            np = 25'(prog_q[c]) + 25'(nv);
            unique case (st_q[c])
                CPT_IDLE, CPT_DRY: begin
                    vel_q[c] <= 32'h0000_0000;
                    if (go && op == `CPT_OP_BEGIN && cs == c[0]
                            && cnt_q[c] != 9'h000) begin
                        st_q[c] <= CPT_RUN;
                        seg_q[c] <= 32'h0000_0000;
                        dist_q[c] <= 32'h0000_0000;
                        prog_q[c] <= 24'h000000;
                    end
                end
                CPT_RUN: begin
                    vel_q[c] <= nv;
                    dist_q[c] <= dist_q[c] + nv;
                    prog_q[c] <= np[23:0];
                    if (np >= 25'(len_m[c][rd_q[c]])) begin
                        prog_q[c] <= 24'h000000;
                        rd_q[c] <= rd_q[c] + 9'h001;
                        seg_q[c] <= seg_q[c] + 32'h0000_0001;
                        if (c == int'(csel_q)) begin
                            cx_q <= cx_q + 32'(signed'(dx_m[c][rd_q[c]]));
                            cy_q <= cy_q + 32'(signed'(dy_m[c][rd_q[c]]));
                        end
                        if (cnt_q[c] == 9'h001 && !(push && csel_q == c[0]))
                        begin
                            vel_q[c] <= 32'h0000_0000;
                            st_q[c] <= end_q[c] ? CPT_IDLE : CPT_DRY;
                        end
                    end
                end
            endcase
            if (push && csel_q == c[0]) begin
                wr_q[c] <= wr_q[c] + 9'h001;
                plen_q[c] <= plen_q[c]
                    + 32'(is_arc ? f_arc_len(arg_q[0][15:0], arg_q[2][15:0])
                    : f_line_len(arg_q[0][15:0], arg_q[1][15:0]));
            end
            if (st_q[c] == CPT_RUN && np >= 25'(len_m[c][rd_q[c]]))
                cnt_q[c] <= (push && csel_q == c[0]) ? cnt_q[c] : 9'(cnt_q[c]
                    - 9'h001);
            else if (push && csel_q == c[0])
                cnt_q[c] <= cnt_q[c] + 9'h001;
            if (go && op == `CPT_OP_END && csel_q == c[0])
                end_q[c] <= 1'b1;
            if (go && op == `CPT_OP_CLEAR && cs == c[0]) begin
                wr_q[c] <= 9'h000;
                rd_q[c] <= 9'h000;
                cnt_q[c] <= 9'h000;
                end_q[c] <= 1'b0;
                plen_q[c] <= 32'h0000_0000;
                st_q[c] <= CPT_IDLE;
                vel_q[c] <= 32'h0000_0000;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// command blocking for await and trippoint
logic blk_trip_q;
logic blk_cs_q;
logic [31:0] trip_goal_q;

always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        blk_q <= 1'b0;
        blk_trip_q <= 1'b0;
        blk_cs_q <= 1'b0;
        trip_goal_q <= 32'h0000_0000;
    end else if (!blk_q) begin
        if (go && (op == `CPT_OP_AWAIT || op == `CPT_OP_TRIP)) begin
            blk_q <= 1'b1;
            blk_trip_q <= op == `CPT_OP_TRIP;
            blk_cs_q <= cs;
            trip_goal_q <= dist_q[cs] + arg_q[0];
        end
    end else if (blk_trip_q) begin
        if (dist_q[blk_cs_q] >= trip_goal_q || st_q[blk_cs_q] != CPT_RUN)
            blk_q <= 1'b0;
    end else if (st_q[blk_cs_q] != CPT_RUN) begin
        blk_q <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////
// readback and outputs
logic [31:0] tinit;
assign tinit = f_tan(tscale_q, tofs_q, dir_m[csel_q][rd_q[csel_q]]);

always_comb begin
    rd_d = 32'h0000_0000;
    rd_ok = 1'b1;
    unique case (i_araddr)
        `CPT_A_ARG0: rd_d = arg_q[0];
        `CPT_A_ARG1: rd_d = arg_q[1];
        `CPT_A_ARG2: rd_d = arg_q[2];
        `CPT_A_TSCALE: rd_d = tscale_q;
        `CPT_A_TOFS: rd_d = tofs_q;
        `CPT_A_SPEED_S: rd_d = speed_q[0];
        `CPT_A_SPEED_T: rd_d = speed_q[1];
        `CPT_A_ACCEL_S: rd_d = accel_q[0];
        `CPT_A_ACCEL_T: rd_d = accel_q[1];
        `CPT_A_DECEL_S: rd_d = decel_q[0];
        `CPT_A_DECEL_T: rd_d = decel_q[1];
        `CPT_A_RATIO_S: rd_d = ratio_q[0];
        `CPT_A_RATIO_T: rd_d = ratio_q[1];
        `CPT_A_SMOOTH_S: rd_d = 32'(smooth_q[0]);
        `CPT_A_SMOOTH_T: rd_d = 32'(smooth_q[1]);
        `CPT_A_FREE: rd_d = 32'(`CPT_CAP - cnt_q[csel_q]);
        `CPT_A_SEGCNT: rd_d = seg_q[csel_q];
        `CPT_A_DIST: rd_d = dist_q[csel_q];
        `CPT_A_CORNX: rd_d = cx_q;
        `CPT_A_CORNY: rd_d = cy_q;
        `CPT_A_PLEN: rd_d = plen_q[csel_q];
        `CPT_A_TINIT: rd_d = tinit;
        `CPT_A_STATUS: rd_d = {22'h0, blk_q, csel_q, end_q[1], end_q[0],
            st_q[1], st_q[0]};
        `CPT_A_PLANE: rd_d = 32'(plane_q);
        `CPT_A_CMD: rd_d = 32'h0000_0000;
        default: rd_ok = 1'b0;
    endcase
end

always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        o_seq_run <= 2'h0;
        o_vel <= 32'h0000_0000;
        o_tan_target <= 32'h0000_0000;
        o_tan_en <= 1'b0;
        o_plane_axes <= `CPT_PLANE_RST;
    end else begin
        o_seq_run <= {st_q[1] == CPT_RUN, st_q[0] == CPT_RUN};
        o_vel <= vel_q[csel_q];
        o_plane_axes <= plane_q;
        o_tan_en <= plane_q[11:8] != `CPT_AXIS_NONE;
        if (st_q[csel_q] == CPT_RUN && plane_q[11:8] != `CPT_AXIS_NONE)
            o_tan_target <= tinit;
    end
end

////////////////////////////////////////////////////////////////////////////
// checks
a_free_full: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b) go && (op == `CPT_OP_LINE || op == `CPT_OP_ARC)
    && cnt_q[csel_q] == `CPT_CAP && st_q[csel_q] != CPT_RUN
    |=> cnt_q[csel_q] == `CPT_CAP) else $error("buffer overfilled");
a_push_free: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b) push && !(st_q[csel_q] == CPT_RUN)
    |=> cnt_q[csel_q] == $past(cnt_q[csel_q]) + 9'h001)
    else $error("push lost");
a_tan_off: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b) plane_q[11:8] == `CPT_AXIS_NONE |=> !o_tan_en)
    else $error("tangent not off");
a_dry_stop: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b) st_q[0] == CPT_RUN ##1 st_q[0] == CPT_DRY
    |-> vel_q[0] == 32'h0) else $error("dry stop not instant");
a_begin_run: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b) go && op == `CPT_OP_BEGIN
    && st_q[cs] == CPT_IDLE && cnt_q[cs] != 9'h0
    |=> st_q[$past(cs)] == CPT_RUN) else $error("begin ignored");
a_clear_empty: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b) go && op == `CPT_OP_CLEAR
    |=> cnt_q[$past(cs)] == 9'h0 && plen_q[$past(cs)] == 32'h0)
    else $error("clear failed");
a_await_hold: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b) blk_q && !blk_trip_q && st_q[blk_cs_q] == CPT_RUN
    |=> blk_q) else $error("await released early");
a_trip_hold: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b) blk_q && blk_trip_q && st_q[blk_cs_q] == CPT_RUN
    && dist_q[blk_cs_q] < trip_goal_q |=> blk_q)
    else $error("trip released early");
a_dist_grow: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b) st_q[0] == CPT_RUN
    |=> dist_q[0] > $past(dist_q[0]) || st_q[0] != CPT_RUN)
    else $error("distance stalled");
a_seg_step: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b) st_q[0] == CPT_RUN && $past(st_q[0]) == CPT_RUN
    |-> seg_q[0] - $past(seg_q[0]) <= 32'h1) else $error("segment jump");

endmodule : cpt_path_seq

// *** core/cpt_consts.svh ***
// register offsets, opcodes, reset values and fixed-point constants
`ifndef CPT_CONSTS_SVH
`define CPT_CONSTS_SVH
`define CPT_A_CMD 8'h00
`define CPT_A_ARG0 8'h04
`define CPT_A_ARG1 8'h08
`define CPT_A_ARG2 8'h0C
`define CPT_A_TSCALE 8'h10
`define CPT_A_TOFS 8'h14
`define CPT_A_SPEED_S 8'h18
`define CPT_A_SPEED_T 8'h1C
`define CPT_A_ACCEL_S 8'h20
`define CPT_A_ACCEL_T 8'h24
`define CPT_A_DECEL_S 8'h28
`define CPT_A_DECEL_T 8'h2C
`define CPT_A_RATIO_S 8'h30
`define CPT_A_RATIO_T 8'h34
`define CPT_A_SMOOTH_S 8'h38
`define CPT_A_SMOOTH_T 8'h3C
`define CPT_A_FREE 8'h40
`define CPT_A_SEGCNT 8'h44
`define CPT_A_DIST 8'h48
`define CPT_A_CORNX 8'h4C
`define CPT_A_CORNY 8'h50
`define CPT_A_PLEN 8'h54
`define CPT_A_TINIT 8'h58
`define CPT_A_STATUS 8'h5C
`define CPT_A_PLANE 8'h60
`define CPT_OP_PLANE 4'h1
`define CPT_OP_CSEL 4'h2
`define CPT_OP_BEGIN 4'h3
`define CPT_OP_CLEAR 4'h4
`define CPT_OP_END 4'h5
`define CPT_OP_LINE 4'h6
`define CPT_OP_ARC 4'h7
`define CPT_OP_AWAIT 4'h8
`define CPT_OP_TRIP 4'h9
`define CPT_CS_BIT 4
`define CPT_AXIS_NONE 4'hF
`define CPT_PLANE_RST 12'hF10
`define CPT_RATIO_RST 32'h0000_2710
`define CPT_RATIO_MUL 32'h0000_1A37
`define CPT_RATIO_SH 26
`define CPT_ARC_MUL 16'h0478
`define CPT_FIX_SH 16
`define CPT_QUARTER 16'h005A
`define CPT_CAP 9'h1FF
`define CPT_RESP_OK 2'h0
`define CPT_RESP_ERR 2'h2
`endif

// *** core/cpt_pkg.sv ***
// types shared by the path sequencer
package cpt_pkg;
    typedef enum logic [2:0] {
        CPT_IDLE = 3'b001,
        CPT_RUN = 3'b010,
        CPT_DRY = 3'b100
    } cpt_run_e;
    typedef logic [8:0] cpt_ptr_t;
endpackage : cpt_pkg

// *** tb/cpt_host_model.sv ***
// axi4-lite host issuing register writes and reads
`timescale 1ns/10ps
module cpt_host_model (
    input wire logic i_ref_clk,
    input wire logic i_awready,
    input wire logic i_wready,
    input wire logic [1:0] i_bresp,
    input wire logic i_bvalid,
    input wire logic i_arready,
    input wire logic [31:0] i_rdata,
    input wire logic [1:0] i_rresp,
    input wire logic i_rvalid,
    output logic [7:0] o_awaddr = 8'h00,
    output logic o_awvalid = 1'b0,
    output logic [31:0] o_wdata = 32'h0,
    output logic [3:0] o_wstrb = 4'hF,
    output logic o_wvalid = 1'b0,
    output logic o_bready = 1'b0,
    output logic [7:0] o_araddr = 8'h00,
    output logic o_arvalid = 1'b0,
    output logic o_rready = 1'b0
);
    int tout = 0;
    logic [1:0] resp;
    task wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge i_ref_clk);
        o_awaddr <= a;
        o_wdata <= d;
        o_awvalid <= 1'b1;
        o_wvalid <= 1'b1;
        o_bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge i_ref_clk);
            if (o_awvalid && i_awready) o_awvalid <= 1'b0;
            if (o_wvalid && i_wready) begin
                o_wvalid <= 1'b0;
                o_wdata <= ~d;
            end
            if (i_bvalid) break;
        end
        o_bready <= 1'b0;
        resp = i_bresp;
        if (n == 100) tout++;
    endtask : wr
    task rd(input logic [7:0] a, output logic [31:0] d);
        int n;
        @(posedge i_ref_clk);
        o_araddr <= a;
        o_arvalid <= 1'b1;
        o_rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge i_ref_clk);
            if (o_arvalid && i_arready) o_arvalid <= 1'b0;
            if (i_rvalid) break;
        end
        o_rready <= 1'b0;
        d = i_rdata;
        resp = i_rresp;
        if (n == 100) tout++;
    endtask : rd
endmodule : cpt_host_model

// *** tb/coordinated_path_tangent_axis_tb.sv ***
// self-checking bench for the path sequencer
`timescale 1ns/10ps
`include "cpt_consts.svh"
module coordinated_path_tangent_axis_tb
    import cpt_pkg::*;
();
    logic clk = 1'b0, rst_b = 1'b0, awvalid, awready, wvalid, wready;
    logic bvalid, bready, arvalid, arready, rvalid, rready, tan_en;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, vel, tan_t, v, sc, ofs, e;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, run;
    logic [11:0] axes;
    int bad_count = 0, checked = 0, seed = 32'h621A4B9C, q[$], n;
    longint p;
    cpt_path_seq dut_u (.i_ref_clk(clk), .i_rst_b(rst_b),
        .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
        .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
        .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
        .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
        .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
        .o_rvalid(rvalid), .i_rready(rready), .o_seq_run(run),
        .o_vel(vel), .o_tan_target(tan_t), .o_tan_en(tan_en),
        .o_plane_axes(axes));
    cpt_host_model host_u (.i_ref_clk(clk), .i_awready(awready),
        .i_wready(wready), .i_bresp(bresp), .i_bvalid(bvalid),
        .i_arready(arready), .i_rdata(rdata), .i_rresp(rresp),
        .i_rvalid(rvalid), .o_awaddr(awaddr), .o_awvalid(awvalid),
        .o_wdata(wdata), .o_wstrb(wstrb), .o_wvalid(wvalid),
        .o_bready(bready), .o_araddr(araddr), .o_arvalid(arvalid),
        .o_rready(rready));
    initial begin
        forever #50 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////
    task wrap_up;
        bad_count += host_u.tout;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    task chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
        checked++;
        if (sn !== ex) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, ex, sn);
        end
    endtask : chk
    task rc(input logic [7:0] a, input logic [31:0] ex, input string nm);
        host_u.rd(a, v);
        chk(nm, ex, v);
    endtask : rc
    task op(input logic [3:0] o, input logic s);
        host_u.wr(`CPT_A_CMD, {27'h0, s, o});
    endtask : op
    task args(input logic [31:0] a0, input logic [31:0] a2);
        host_u.wr(`CPT_A_ARG0, a0);
        host_u.wr(`CPT_A_ARG1, 32'h0);
        host_u.wr(`CPT_A_ARG2, a2);
    endtask : args
    task seg(input logic [3:0] o, input int l);
        op(o, 1'b0);
        if (q.size() < 511) q.push_back(l);
    endtask : seg
    task wst(input logic [9:0] m, input logic [9:0] st);
        n = 0;
        do begin
            host_u.rd(`CPT_A_STATUS, v);
            n++;
        end while ((v[9:0] & m) !== st && n < 3000);
        chk("state", {22'h0, st}, {22'h0, v[9:0] & m});
        if ((v[9:0] & m) !== st) host_u.tout++;
    endtask : wst
    ////////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 100000 && host_u.tout == 0; i++)
            @(posedge clk);
        bad_count++;
        wrap_up;
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chk("axes", 32'hF10, {20'h0, axes});
        rc(`CPT_A_FREE, 32'h1FF, "free");
        rc(`CPT_A_RATIO_S, `CPT_RATIO_RST, "ratio");
        rc(`CPT_A_STATUS, 32'h9, "status");
        rc(8'h64, 32'h0, "unmapped");
        chk("resp", 32'h2, {30'h0, host_u.resp});
        $display("test reset done");
        sc = $random(seed) & 32'h00FF_FFFF;
        ofs = $random(seed);
        args(32'h210, 32'h0);
        op(`CPT_OP_PLANE, 1'b0);
        @(posedge clk);
        chk("axes", 32'h210, {20'h0, axes});
        chk("tan en", 32'h1, {31'h0, tan_en});
        host_u.wr(`CPT_A_TSCALE, sc);
        host_u.wr(`CPT_A_TOFS, ofs);
        rc(`CPT_A_TSCALE, sc, "scale");
        rc(`CPT_A_TOFS, ofs, "offset");
        args(32'h12C, 32'h5A);
        seg(`CPT_OP_LINE, 300);
        p = $signed(sc) * 90;
        e = ofs + 32'(p >>> 16);
        rc(`CPT_A_TINIT, e, "tinit");
        args(32'h3E8, 32'h5A);
        seg(`CPT_OP_ARC, (1000 * 90 * 32'h478) >> 16);
        rc(`CPT_A_FREE, 32'(511 - q.size()), "free");
        rc(`CPT_A_PLEN, 32'(q.sum()), "plen");
        op(`CPT_OP_END, 1'b0);
        op(`CPT_OP_BEGIN, 1'b0);
        op(`CPT_OP_AWAIT, 1'b0);
        host_u.rd(`CPT_A_STATUS, v);
        chk("blocked", 32'h1, {31'h0, v[9]});
        chk("tan target", e, tan_t);
        wst(10'h7, 10'h1);
        rc(`CPT_A_SEGCNT, 32'h2, "segcnt");
        rc(`CPT_A_CORNX, 32'h12C, "corner");
        host_u.rd(`CPT_A_DIST, v);
        chk("dist", 32'(q.sum()), v);
        $display("test path done");
        op(`CPT_OP_CLEAR, 1'b0);
        q.delete();
        rc(`CPT_A_FREE, 32'h1FF, "free");
        rc(`CPT_A_PLEN, 32'h0, "plen");
        args(32'h32, 32'h0);
        seg(`CPT_OP_LINE, 50);
        op(`CPT_OP_BEGIN, 1'b0);
        wst(10'h7, 10'h4);
        chk("vel", 32'h0, vel);
        $display("test dry done");
        op(`CPT_OP_CLEAR, 1'b0);
        q.delete();
        repeat (512) seg(`CPT_OP_LINE, 50);
        rc(`CPT_A_FREE, 32'h0, "free");
        rc(`CPT_A_PLEN, 32'(q.sum()), "plen");
        op(`CPT_OP_CSEL, 1'b1);
        rc(`CPT_A_FREE, 32'h1FF, "free t");
        $display("test fill done");
        e = 32'h14 + ($random(seed) & 32'h1F);
        host_u.wr(`CPT_A_SPEED_T, e);
        host_u.wr(`CPT_A_ACCEL_T, 32'h3E8);
        host_u.wr(`CPT_A_DECEL_T, 32'h3E8);
        host_u.wr(`CPT_A_RATIO_T, 32'h1388);
        host_u.wr(`CPT_A_SMOOTH_T, 32'h0);
        p = (longint'(e) * 5000 * `CPT_RATIO_MUL) >> `CPT_RATIO_SH;
        args(32'h4E20, 32'h0);
        op(`CPT_OP_LINE, 1'b0);
        op(`CPT_OP_END, 1'b0);
        op(`CPT_OP_BEGIN, 1'b1);
        repeat (30) @(posedge clk);
        chk("run", 32'h2, {30'h0, run});
        chk("vel t", 32'(p), vel);
        host_u.rd(`CPT_A_DIST, sc);
        host_u.wr(`CPT_A_ARG0, 32'h7D0);
        op(`CPT_OP_TRIP, 1'b1);
        op(`CPT_OP_CSEL, 1'b0);
        host_u.rd(`CPT_A_STATUS, v);
        chk("held", 32'h3, {30'h0, v[9:8]});
        wst(10'h200, 10'h0);
        host_u.rd(`CPT_A_DIST, v);
        chk("trip", 32'h1, {31'h0, v >= sc + 32'h7D0});
        chk("run", 32'h2, {30'h0, run});
        $display("test system t done");
        wrap_up;
    end
endmodule : coordinated_path_tangent_axis_tb
